// *** common/uhp_pkg.sv ***
// Package with register map, field layout and types of the host endpoint and power control block.
package uhp_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          EP_NUM         = 8;
  localparam int          EP_W           = 3;
  localparam int          STAT_W         = 16;

  // Register byte addresses.
  localparam logic [7:0]  OFF_GPCS       = 8'h00;
  localparam logic [7:0]  OFF_EP_SEL     = 8'h04;
  localparam logic [7:0]  OFF_EP_SPEED   = 8'h08;
  localparam logic [7:0]  OFF_HUB_ADDR   = 8'h0C;
  localparam logic [7:0]  OFF_EP_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_STAT_CLR   = 8'h14;
  localparam logic [7:0]  OFF_PWR_CFG    = 8'h18;
  localparam logic [7:0]  OFF_PWR_CTRL   = 8'h1C;
  localparam logic [7:0]  OFF_PWR_STAT   = 8'h20;

  // Endpoint select and flag bits.
  localparam int          SEL_EP_LSB     = 0;
  localparam int          DIR_IN_BIT     = 8;
  localparam int          DIR_OUT_BIT    = 9;
  localparam int          SPD_LOW_BIT    = 4;
  localparam int          SPD_HIGH_BIT   = 5;
  localparam int          SPD_FULL_BIT   = 6;

  // Hub setting field layout.
  localparam int          HUB_ADDR_LSB   = 0;
  localparam int          HUB_PORT_LSB   = 8;
  localparam int          HUB_FIELD_W    = 7;
  localparam int          HUB_LOW_BIT    = 16;

  // General control and status bits.
  localparam int          HOST_SEL_BIT   = 0;
  localparam int          SESSION_BIT    = 1;

  // Power configuration field layout.
  localparam int          CFG_FLT_HI_BIT = 0;
  localparam int          CFG_ACT_LSB    = 1;
  localparam int          CFG_SRC_LSB    = 3;
  localparam int          CFG_FILT_BIT   = 5;

  // Power control and status bits.
  localparam int          CTRL_PWR_BIT   = 0;
  localparam int          CTRL_DET_BIT   = 1;
  localparam int          STAT_FLT_BIT   = 0;
  localparam int          STAT_VBUS_BIT  = 1;

  localparam logic [7:0]  FILT_CYCLES    = 8'h28;

  typedef enum logic [1:0] {
    FAULT_ACTION_NONE,
    FAULT_ACTION_TRISTATE,
    FAULT_ACTION_DRIVE_LOW,
    FAULT_ACTION_DRIVE_HIGH
  } uhp_act_t;

  typedef enum logic [1:0] {
    PWR_MANUAL_ACTIVE_LOW,
    PWR_MANUAL_ACTIVE_HIGH,
    PWR_AUTO_ACTIVE_LOW,
    PWR_AUTO_ACTIVE_HIGH
  } uhp_src_t;

  typedef struct packed {
    logic              fault_active_high;
    uhp_act_t          action;
    uhp_src_t          source;
    logic              vbus_glitch_filter_en;
  } uhp_pcfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } uhp_bus_t;

endpackage

// *** core/uhp_vbus_filter.sv ***
// VBUS level glitch filter: synchronises the pin and ignores short drops.
`timescale 1ns/1ps
module uhp_vbus_filter
  import uhp_pkg::*;
(
  // Clock and reset
  input  wire logic REF_CLK_IN,
  input  wire logic RST_N_IN,
  // Control
  input  wire logic filt_en_in,
  input  wire logic vbus_in,
  // Result
  output logic      vbus_ok_out
);

  typedef struct packed {
    logic [1:0] sync;
    logic [7:0] cnt;
    logic       ok;
  } uhp_flt_st_t;

  uhp_flt_st_t st_r;
  uhp_flt_st_t st_nxt;

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.sync    = {st_r.sync[0], vbus_in};
    if (st_r.sync[1] || !filt_en_in)
    begin
      st_nxt.cnt = 8'h00;
      st_nxt.ok  = st_r.sync[1];
    end
    else if (st_r.cnt >= FILT_CYCLES)
    begin
      // Only a drop that outlasts the window is reported; inrush dips are not.
      st_nxt.ok = 1'b0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign vbus_ok_out = st_r.ok;

  property p_filter_hold;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (filt_en_in && st_r.ok && !st_r.sync[1] && st_r.cnt == 8'h00) |=> st_r.ok;
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("VBUS drop passed the filter at once");

endmodule

// *** core/uhp_host_ctrl.sv ***
// Host endpoint settings, host role select and external bus power control.
//
// How it works
// - Each host endpoint keeps a full, low or high speed setting per direction; the IN/OUT flags of the write pick the direction.
// - A status clear write clears exactly the endpoint status bits set in the mask, same layout as the read value.
// - Reading the hub register returns the hub address stored for the selected endpoint and direction.
// - The hub setting holds a 7-bit address in bits 0-6 and a 7-bit port in bits 8-14, kept per direction.
// - A hub write also records the downstream speed, low when its low-speed flag is set.
// - Setting the host select bit in the general control register switches the controller to host role.
// - The fault input signals a fault when it sits at the configured level, low or high.
// - On a fault the power enable output takes the configured action: none, tri-state, low or high.
// - In manual mode the power enable output goes to the configured active level when software enables power.
// - In automatic mode the power enable output goes active whenever a session has been requested.
// - With the filter selected, short drops of VBUS are ignored.
// - In manual mode a power disable command deasserts the power enable output.
// - A power enable command in manual mode asserts the power enable output.
// - Fault detection is switched on and off by software and faults count only while it is on.
`timescale 1ns/1ps
module uhp_host_ctrl
  import uhp_pkg::*;
(
  // Clock and reset
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_N_IN,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RDATA_OUT,
  // Endpoint status events from the transfer engine
  input  wire logic [STAT_W-1:0] EP_STAT_SET_IN,
  input  wire logic [EP_W-1:0]   EP_STAT_EP_IN,
  input  wire logic              EP_STAT_DIR_IN_IN,
  // Pins
  input  wire logic              POWER_FAULT_IN,
  input  wire logic              VBUS_IN,
  output logic                   EXT_POWER_ENABLE_OUT,
  output logic                   EXT_POWER_ENABLE_OE_OUT,
  // Role and VBUS state
  output logic                   HOST_MODE_OUT,
  output logic                   VBUS_OK_OUT
);

  typedef struct packed {
    logic [EP_NUM-1:0][1:0]        spd_in;
    logic [EP_NUM-1:0][1:0]        spd_out;
    logic [EP_NUM-1:0][16:0]       hub_in;
    logic [EP_NUM-1:0][16:0]       hub_out;
    logic [EP_NUM-1:0][STAT_W-1:0] stat_in;
    logic [EP_NUM-1:0][STAT_W-1:0] stat_out;
    logic [EP_W-1:0]               sel_ep;
    logic                          sel_out;
    logic                          host;
    logic                          session;
    uhp_pcfg_t                     cfg;
    logic                          pwr_on;
    logic                          det_en;
    logic                          fault;
    logic [1:0]                    flt_sync;
    logic [DATA_W-1:0]             rdata;
  } uhp_state_t;

  uhp_state_t st_r;
  uhp_state_t st_nxt;
  logic       vbus_ok;
  logic       fault_now;
  logic       pwr_level;
  logic       pwr_active;

  // Chooses the direction of a register access from the flag bits, IN wins over OUT.
  function automatic logic dir_is_out(input logic [DATA_W-1:0] d, input logic dflt);
    if (d[DIR_IN_BIT])
      return 1'b0;
    else if (d[DIR_OUT_BIT])
      return 1'b1;
    else
      return dflt;
  endfunction

  // Speed code 0 full, 1 low, 2 high.
  function automatic logic [1:0] speed_code(input logic [DATA_W-1:0] d, input logic [1:0] old);
    if (d[SPD_LOW_BIT])
      return 2'h1;
    else if (d[SPD_HIGH_BIT])
      return 2'h2;
    else if (d[SPD_FULL_BIT])
      return 2'h0;
    else
      return old;
  endfunction

  uhp_vbus_filter u_filter (
    .REF_CLK_IN  (REF_CLK_IN),
    .RST_N_IN    (RST_N_IN),
    .filt_en_in  (st_r.cfg.vbus_glitch_filter_en),
    .vbus_in     (VBUS_IN),
    .vbus_ok_out (vbus_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Fault and power enable.

  assign fault_now  = st_r.det_en &&
                      (st_r.flt_sync[1] == st_r.cfg.fault_active_high);
  assign pwr_level  = (st_r.cfg.source == PWR_MANUAL_ACTIVE_HIGH) ||
                      (st_r.cfg.source == PWR_AUTO_ACTIVE_HIGH);
  assign pwr_active = (st_r.cfg.source == PWR_AUTO_ACTIVE_LOW || st_r.cfg.source == PWR_AUTO_ACTIVE_HIGH)
                      ? st_r.session
                      : st_r.pwr_on;

  always_comb
  begin
    EXT_POWER_ENABLE_OE_OUT = 1'b1;
    EXT_POWER_ENABLE_OUT    = pwr_active ? pwr_level : !pwr_level;
    if (st_r.fault)
    begin
      // The latched flag keeps the action in force until software clears it.
      case (st_r.cfg.action)
        FAULT_ACTION_TRISTATE:
        begin
          EXT_POWER_ENABLE_OE_OUT = 1'b0;
        end
        FAULT_ACTION_DRIVE_LOW:
        begin
          EXT_POWER_ENABLE_OUT = 1'b0;
        end
        FAULT_ACTION_DRIVE_HIGH:
        begin
          EXT_POWER_ENABLE_OUT = 1'b1;
        end
        default:
        begin
          EXT_POWER_ENABLE_OUT = pwr_active ? pwr_level : !pwr_level;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes, status events and read data.

  always_comb
  begin
    logic          wout;
    logic [EP_W-1:0] wep;
    st_nxt          = st_r;
    st_nxt.flt_sync = {st_r.flt_sync[0], POWER_FAULT_IN};
    wep             = WDATA_IN[SEL_EP_LSB +: EP_W];
    wout            = dir_is_out(WDATA_IN, st_r.sel_out);
    st_nxt.rdata    = '0;

    if (WR_IN)
    begin
      if (ADDR_IN == OFF_GPCS)
      begin
        st_nxt.host    = WDATA_IN[HOST_SEL_BIT];
        st_nxt.session = WDATA_IN[SESSION_BIT];
      end
      else if (ADDR_IN == OFF_EP_SEL)
      begin
        st_nxt.sel_ep  = wep;
        st_nxt.sel_out = wout;
      end
      else if (ADDR_IN == OFF_EP_SPEED)
      begin
        // Endpoint comes from the select register; the write's IN/OUT flags pick the direction, else the selected one.
        if (wout)
          st_nxt.spd_out[st_r.sel_ep] = speed_code(WDATA_IN, st_r.spd_out[st_r.sel_ep]);
        else
          st_nxt.spd_in[st_r.sel_ep]  = speed_code(WDATA_IN, st_r.spd_in[st_r.sel_ep]);
      end
      else if (ADDR_IN == OFF_HUB_ADDR)
      begin
        if (st_r.sel_out)
          st_nxt.hub_out[st_r.sel_ep] = {WDATA_IN[HUB_LOW_BIT], 1'b0,
                                         WDATA_IN[HUB_PORT_LSB +: HUB_FIELD_W], 1'b0,
                                         WDATA_IN[HUB_ADDR_LSB +: HUB_FIELD_W]};
        else
          st_nxt.hub_in[st_r.sel_ep]  = {WDATA_IN[HUB_LOW_BIT], 1'b0,
                                         WDATA_IN[HUB_PORT_LSB +: HUB_FIELD_W], 1'b0,
                                         WDATA_IN[HUB_ADDR_LSB +: HUB_FIELD_W]};
      end
      else if (ADDR_IN == OFF_PWR_CFG)
      begin
        // Fields are picked one by one, since the struct packs them in the opposite order to the register.
        st_nxt.cfg.fault_active_high     = WDATA_IN[CFG_FLT_HI_BIT];
        st_nxt.cfg.action                = uhp_act_t'(WDATA_IN[CFG_ACT_LSB +: 2]);
        st_nxt.cfg.source                = uhp_src_t'(WDATA_IN[CFG_SRC_LSB +: 2]);
        st_nxt.cfg.vbus_glitch_filter_en = WDATA_IN[CFG_FILT_BIT];
      end
      else if (ADDR_IN == OFF_PWR_CTRL)
      begin
        st_nxt.pwr_on = WDATA_IN[CTRL_PWR_BIT];
        st_nxt.det_en = WDATA_IN[CTRL_DET_BIT];
      end
      else if (ADDR_IN == OFF_PWR_STAT)
      begin
        if (WDATA_IN[STAT_FLT_BIT])
          st_nxt.fault = 1'b0;
      end
    end

    // Clear first, then set, so a status event in the clearing cycle survives.
    if (WR_IN && ADDR_IN == OFF_STAT_CLR)
    begin
      if (st_r.sel_out)
        st_nxt.stat_out[st_r.sel_ep] = st_r.stat_out[st_r.sel_ep] & ~WDATA_IN[STAT_W-1:0];
      else
        st_nxt.stat_in[st_r.sel_ep]  = st_r.stat_in[st_r.sel_ep] & ~WDATA_IN[STAT_W-1:0];
    end
    if (EP_STAT_DIR_IN_IN)
      st_nxt.stat_in[EP_STAT_EP_IN]  = st_nxt.stat_in[EP_STAT_EP_IN] | EP_STAT_SET_IN;
    else
      st_nxt.stat_out[EP_STAT_EP_IN] = st_nxt.stat_out[EP_STAT_EP_IN] | EP_STAT_SET_IN;

    if (fault_now)
      st_nxt.fault = 1'b1;

    if (RD_IN)
    begin
      if (ADDR_IN == OFF_GPCS)
        st_nxt.rdata = {30'h0, st_r.session, st_r.host};
      else if (ADDR_IN == OFF_EP_SEL)
        st_nxt.rdata = {22'h0, st_r.sel_out, !st_r.sel_out, 5'h0, st_r.sel_ep};
      else if (ADDR_IN == OFF_EP_SPEED)
        st_nxt.rdata = {30'h0, st_r.sel_out ? st_r.spd_out[st_r.sel_ep] : st_r.spd_in[st_r.sel_ep]};
      else if (ADDR_IN == OFF_HUB_ADDR)
        st_nxt.rdata = {15'h0, st_r.sel_out ? st_r.hub_out[st_r.sel_ep] : st_r.hub_in[st_r.sel_ep]};
      else if (ADDR_IN == OFF_EP_STATUS)
        st_nxt.rdata = {16'h0, st_r.sel_out ? st_r.stat_out[st_r.sel_ep] : st_r.stat_in[st_r.sel_ep]};
      else if (ADDR_IN == OFF_PWR_CFG)
        st_nxt.rdata = {26'h0, st_r.cfg.vbus_glitch_filter_en, st_r.cfg.source, st_r.cfg.action,
                        st_r.cfg.fault_active_high};
      else if (ADDR_IN == OFF_PWR_CTRL)
        st_nxt.rdata = {30'h0, st_r.det_en, st_r.pwr_on};
      else if (ADDR_IN == OFF_PWR_STAT)
        st_nxt.rdata = {30'h0, vbus_ok, st_r.fault};
      else
        st_nxt.rdata = '0;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign RDATA_OUT     = st_r.rdata;
  assign HOST_MODE_OUT = st_r.host;
  assign VBUS_OK_OUT   = vbus_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_hub_write;
    WR_IN && ADDR_IN == OFF_HUB_ADDR && !st_r.sel_out;
  endsequence

  sequence s_hub_read;
    RD_IN && ADDR_IN == OFF_HUB_ADDR && !st_r.sel_out;
  endsequence

  property p_hub_rw;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    s_hub_write ##2 (s_hub_read and $stable(st_r.sel_ep)) |=>
      RDATA_OUT[14:0] == {$past(WDATA_IN[14:8], 3), 1'b0, $past(WDATA_IN[6:0], 3)};
  endproperty
  a_hub_rw: assert property (p_hub_rw) else $error("Hub setting read back wrong");

  property p_hub_low;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    s_hub_write |=> st_r.hub_in[$past(st_r.sel_ep)][16] == $past(WDATA_IN[HUB_LOW_BIT]);
  endproperty
  a_hub_low: assert property (p_hub_low) else $error("Low speed flag of hub write not kept");

  property p_hub_fields;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    s_hub_write |=> st_r.hub_in[$past(st_r.sel_ep)][7] == 1'b0 &&
                    st_r.hub_in[$past(st_r.sel_ep)][14:8] == $past(WDATA_IN[14:8]);
  endproperty
  a_hub_fields: assert property (p_hub_fields) else $error("Hub port field misplaced");

  property p_speed_low;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == OFF_EP_SPEED && WDATA_IN[SPD_LOW_BIT] && WDATA_IN[DIR_IN_BIT]) |=>
      st_r.spd_in[$past(st_r.sel_ep)] == 2'h1;
  endproperty
  a_speed_low: assert property (p_speed_low) else $error("Low speed not stored");

  property p_stat_clear;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == OFF_STAT_CLR && !st_r.sel_out && EP_STAT_SET_IN == '0) |=>
      (st_r.stat_in[$past(st_r.sel_ep)] & $past(WDATA_IN[STAT_W-1:0])) == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("Masked status bits not cleared");

  property p_host;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == OFF_GPCS && WDATA_IN[HOST_SEL_BIT]) |=> HOST_MODE_OUT;
  endproperty
  a_host: assert property (p_host) else $error("Host role not taken");

  property p_fault_latch;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    fault_now |=> st_r.fault;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("Fault flag not latched");

  property p_no_detect;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (!st_r.det_en && !st_r.fault) |=> !st_r.fault;
  endproperty
  a_no_detect: assert property (p_no_detect) else $error("Fault latched while detection off");

  property p_fault_level;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (st_r.det_en && st_r.flt_sync[1] == st_r.cfg.fault_active_high) |=> st_r.fault;
  endproperty
  a_fault_level: assert property (p_fault_level) else $error("Fault level ignored");

  property p_fault_tri;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (st_r.fault && st_r.cfg.action == FAULT_ACTION_TRISTATE) |-> !EXT_POWER_ENABLE_OE_OUT;
  endproperty
  a_fault_tri: assert property (p_fault_tri) else $error("Fault tri-state not applied");

  property p_manual_on;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == OFF_PWR_CTRL && WDATA_IN[CTRL_PWR_BIT] && !st_r.fault &&
     st_r.cfg.source == PWR_MANUAL_ACTIVE_HIGH) ##1 !st_r.fault |-> EXT_POWER_ENABLE_OUT;
  endproperty
  a_manual_on: assert property (p_manual_on) else $error("Manual power enable not driven");

  property p_manual_off;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (WR_IN && ADDR_IN == OFF_PWR_CTRL && !WDATA_IN[CTRL_PWR_BIT] &&
     st_r.cfg.source == PWR_MANUAL_ACTIVE_LOW) ##1 !st_r.fault |-> EXT_POWER_ENABLE_OUT;
  endproperty
  a_manual_off: assert property (p_manual_off) else $error("Power disable left output active");

  property p_auto;
    @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
    (!st_r.fault && st_r.cfg.source == PWR_AUTO_ACTIVE_HIGH) |-> EXT_POWER_ENABLE_OUT == st_r.session;
  endproperty
  a_auto: assert property (p_auto) else $error("Automatic power enable not following session");

endmodule

// *** verification/uhp_psw_model.sv ***
// External power switch and VBUS source facing the host power pins.
`timescale 1ns/1ps
module uhp_psw_model
(
  // Clock
  input  wire logic clk_in,
  // From the controller, plus the enable polarity that the bench sets
  input  wire logic en_in,
  input  wire logic oe_in,
  input  wire logic act_high_in,
  // Bench controls
  input  wire logic flt_cmd_in,
  input  wire logic flt_high_in,
  input  wire logic dip_in,
  // To the controller
  output logic      fault_pin_out,
  output logic      vbus_out
);
  logic last_r = 1'b0;
  logic pin;
  // The enable line has no pull, so a released pin shows the inverse of its last driven level.
  always_ff @(posedge clk_in)
  begin
    if (oe_in)
      last_r <= en_in;
  end
  assign pin           = oe_in ? en_in : ~last_r;
  assign fault_pin_out = flt_high_in ? flt_cmd_in : ~flt_cmd_in;
  assign vbus_out      = (pin == act_high_in) & ~dip_in;
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the host endpoint and power control block.
`timescale 1ns/1ps
module tb
  import uhp_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_s;
  logic              rd_s;
  logic [DATA_W-1:0] rdata;
  logic [STAT_W-1:0] st_set;
  logic [EP_W-1:0]   st_ep;
  logic              st_dir;
  logic              pf;
  logic              vb;
  logic              pen;
  logic              poe;
  logic              host;
  logic              vok;
  logic              act_high;
  logic              flt_cmd;
  logic              flt_high;
  logic              dip;
  logic [31:0]       hub_m [16] = '{default: '0};
  logic [31:0]       spd_m [16] = '{default: '0};
  logic [15:0]       st_m [16]  = '{default: '0};
  integer            seed       = 32'hFD5D9707;
  int                n_mismatch = 0;
  int                check_count = 0;

  uhp_host_ctrl uhp_host_ctrl_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .EP_STAT_SET_IN(st_set), .EP_STAT_EP_IN(st_ep),
    .EP_STAT_DIR_IN_IN(st_dir), .POWER_FAULT_IN(pf), .VBUS_IN(vb), .EXT_POWER_ENABLE_OUT(pen),
    .EXT_POWER_ENABLE_OE_OUT(poe), .HOST_MODE_OUT(host), .VBUS_OK_OUT(vok));
  uhp_psw_model uhp_psw_model_i (.clk_in(clk), .en_in(pen), .oe_in(poe), .act_high_in(act_high),
    .flt_cmd_in(flt_cmd), .flt_high_in(flt_high), .dip_in(dip), .fault_pin_out(pf), .vbus_out(vb));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask

  // Index bit 0 is the direction (1 = IN), bits 3:1 the endpoint.
  task automatic sel(input logic [3:0] i);
    wr(OFF_EP_SEL, {22'h0, ~i[0], i[0], 5'h0, i[3:1]});
  endtask

  task automatic readall();
    for (int i = 0; i < 16; i++)
    begin
      sel(4'(i));
      rdc(OFF_HUB_ADDR, hub_m[i], 32'hFFFFFFFF);
      rdc(OFF_EP_SPEED, spd_m[i], 32'h3);
    end
  endtask

  // A drop is watched for its whole length plus a settling tail, since the filter adds latency.
  task automatic dipt(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    dip <= 1'b1;
    for (int i = 0; i < n + FILT_CYCLES + 20; i++)
    begin
      @(posedge clk);
      if (i == n)
        dip <= 1'b0;
      if (vok !== 1'b1)
        seen = 1'b1;
    end
    chk(seen, exp);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] m;
    logic [3:0]  k;
    logic        on;
    addr     = '0;
    wdata    = '0;
    wr_s     = 1'b0;
    rd_s     = 1'b0;
    st_set   = '0;
    st_ep    = '0;
    st_dir   = 1'b0;
    act_high = 1'b0;
    flt_cmd  = 1'b0;
    flt_high = 1'b0;
    dip      = 1'b0;
    rst_n    = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({host, poe, pen}, 3'b011);
    readall();
    rdc(OFF_PWR_CTRL, 32'h0, 32'h3);
    wr(OFF_GPCS, 32'h1);
    #1 chk(host, 1'b1);
    repeat (12)
    begin
      r = $random(seed);
      k = r[23:20];
      sel(k);
      wr(OFF_HUB_ADDR, r);
      rdc(OFF_HUB_ADDR, r & 32'h17F7F, 32'hFFFFFFFF);
      hub_m[k] = r & 32'h17F7F;
      m = r[25:24] == 2'h0 ? 32'h40 : (r[25] ? 32'h20 : 32'h10);
      spd_m[k] = r[25:24] == 2'h0 ? 32'h0 : (r[25] ? 32'h2 : 32'h1);
      wr(OFF_EP_SPEED, m | {22'h0, ~k[0], k[0], 8'h0} | 32'h1000);
    end
    wr(8'h44, 32'hFFFFFFFF);
    rdc(8'h44, 32'h0, 32'hFFFFFFFF);
    readall();
    repeat (4)
    begin
      r = $random(seed);
      m = $random(seed);
      k = r[3:0];
      sel(k);
      st_ep  <= k[3:1];
      st_dir <= k[0];
      st_set <= r[31:16];
      @(posedge clk);
      st_set <= '0;
      st_m[k] = st_m[k] | r[31:16];
      rdc(OFF_EP_STATUS, st_m[k], 32'hFFFF);
      wr(OFF_STAT_CLR, m);
      st_m[k] = st_m[k] & ~m[15:0];
      rdc(OFF_EP_STATUS, st_m[k], 32'hFFFF);
    end
    for (int s = 0; s < 4; s++)
      for (int q = 0; q < 4; q++)
      begin
        act_high <= s[0];
        wr(OFF_PWR_CFG, 32'(s) << CFG_SRC_LSB);
        wr(OFF_GPCS, {30'h0, q[1], 1'b1});
        wr(OFF_PWR_CTRL, {31'h0, q[0]});
        on = s[1] ? q[1] : q[0];
        #1 chk({poe, pen}, {1'b1, on ~^ s[0]});
      end
    act_high <= 1'b1;
    for (int a = 0; a < 4; a++)
      for (int p = 0; p < 2; p++)
      begin
        flt_high <= p[0];
        wr(OFF_PWR_CFG, {27'h0, 2'h1, 2'(a), p[0]});
        wr(OFF_PWR_CTRL, 32'h3);
        wr(OFF_PWR_STAT, 32'h1);
        flt_cmd <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk({poe, pen & (a != 1)}, {a != 1, a == 0 || a == 3});
        rdc(OFF_PWR_STAT, 32'h1, 32'h1);
        @(posedge clk);
        flt_cmd <= 1'b0;
        repeat (5) @(posedge clk);
        rdc(OFF_PWR_STAT, 32'h1, 32'h1);
        wr(OFF_PWR_STAT, 32'h1);
        rdc(OFF_PWR_STAT, 32'h0, 32'h1);
        chk({poe, pen}, 2'b11);
      end
    wr(OFF_PWR_CTRL, 32'h1);
    flt_cmd <= 1'b1;
    repeat (5) @(posedge clk);
    rdc(OFF_PWR_STAT, 32'h0, 32'h1);
    chk({poe, pen}, 2'b11);
    @(posedge clk);
    flt_cmd  <= 1'b0;
    flt_high <= 1'b0;
    wr(OFF_PWR_CFG, 32'h28);
    repeat (FILT_CYCLES + 20) @(posedge clk);
    dipt(FILT_CYCLES / 4, 1'b0);
    dipt(FILT_CYCLES * 2, 1'b1);
    wr(OFF_PWR_CFG, 32'h08);
    dipt(FILT_CYCLES / 4, 1'b1);
    close_out();
  end
endmodule
